/* hw/dadc_device.sv */
// Converter-side control: demux, output clock, power-down and calibration sequencing.
// Assumes pclk is the sample clock and sample codes arrive from logic on pclk.
`timescale 1ns/1ns
`default_nettype none
module dadc_device #(
    parameter int PWRUP_SHORT = 64,
    parameter int PWRUP_LONG = 256,
    parameter int CAL_CYCLES = 512
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] i_code,
    input wire logic [7:0] i_alt_code,
    input wire logic [7:0] q_code,
    input wire logic [7:0] q_alt_code,
    dadc_link_if.dev link
);
    if (PWRUP_SHORT < 1 || PWRUP_LONG < 1 || PWRUP_LONG > 65535 || PWRUP_SHORT > 65535
        || CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_param
        $error("dadc_device: parameter out of range");
    end

    localparam int SW = 30;
    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic s_pd;
    logic s_qpd;
    logic s_edge;
    logic s_lvl;
    logic s_ddr;
    logic s_ser;
    logic s_cal;
    logic s_dly;
    logic s_flt;
    logic s_tgl;
    logic [3:0] s_addr;
    logic [15:0] s_wdata;

    assign raw = {link.full_power_down, link.q_channel_power_down, link.output_edge_select,
                  link.output_level_select, link.ddr_select, link.serial_mode,
                  link.cal_request, link.calibration_delay_select_level,
                  link.calibration_delay_select_float, link.reg_toggle,
                  link.reg_addr, link.reg_wdata};

    dadc_sync #(.W(SW)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(raw),
        .q(syn)
    );

    assign {s_pd, s_qpd, s_edge, s_lvl, s_ddr, s_ser, s_cal, s_dly, s_flt, s_tgl,
            s_addr, s_wdata} = syn;

    dadc_pkg::dadc_dev_st_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic [6:0] lo_q, lo_d;
    logic [6:0] hi_q, hi_d;
    logic tgl_q, tgl_d;
    logic [15:0] ilv_q, ilv_d;
    logic armed_q, armed_d;
    logic qoff_q, qoff_d;
    logic ld_q, ld_d;
    logic cal_go;
    logic fast;

    // Control group
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        lo_d = lo_q;
        hi_d = hi_q;
        tgl_d = s_tgl;
        ilv_d = ilv_q;
        armed_d = armed_q;
        qoff_d = qoff_q;
        cal_go = 1'b0;
        fast = s_ser || s_flt || !s_dly;
        // Word loads a cycle after its toggle, so all its bits have settled
        ld_d = (s_tgl != tgl_q) && (s_addr == dadc_pkg::REG_ILV);
        if (ld_q) begin
            ilv_d = s_wdata;
        end
        // Floating only counts after the pin was seen low
        if (!s_ser && !s_flt && !s_dly) begin
            armed_d = 1'b1;
        end
        // Noise on the request pin must not start a calibration
        if (st_q != dadc_pkg::DS_RUN || s_pd) begin
            lo_d = 7'h00;
            hi_d = 7'h00;
        end else if (!s_cal) begin
            hi_d = 7'h00;
            lo_d = dadc_pkg::inc7(lo_q, dadc_pkg::CAL_LOW_MIN);
        end else if (lo_q == dadc_pkg::CAL_LOW_MIN) begin
            hi_d = dadc_pkg::inc7(hi_q, dadc_pkg::CAL_START_DLY);
            if (hi_d == dadc_pkg::CAL_START_DLY) begin
                cal_go = 1'b1;
                lo_d = 7'h00;
                hi_d = 7'h00;
            end
        end
        case (st_q)
            // Holds here while full power-down is high; counts toward calibration only once it is released
            dadc_pkg::DS_PWRUP: begin
                if (!s_pd) begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_q >= (fast ? 16'(PWRUP_SHORT) : 16'(PWRUP_LONG))) begin
                        st_d = dadc_pkg::DS_CAL;
                        cnt_d = 16'h0000;
                    end
                end
            end
            dadc_pkg::DS_RUN: begin
                cnt_d = 16'h0000;
                if (cal_go) begin
                    st_d = dadc_pkg::DS_CAL;
                end else if (s_pd) begin
                    st_d = dadc_pkg::DS_PD;
                end
            end
            dadc_pkg::DS_CAL: begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(CAL_CYCLES - 1)) begin
                    cnt_d = 16'h0000;
                    st_d = s_pd ? dadc_pkg::DS_PD : dadc_pkg::DS_RUN;
                end
            end
            dadc_pkg::DS_PD: begin
                if (!s_pd) begin
                    st_d = dadc_pkg::DS_RUN;
                end
            end
            default: begin
                st_d = dadc_pkg::DS_PWRUP;
            end
        endcase
        if (st_d != dadc_pkg::DS_CAL) begin
            qoff_d = s_qpd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= dadc_pkg::DS_PWRUP;
            cnt_q <= 16'h0000;
            lo_q <= 7'h00;
            hi_q <= 7'h00;
            tgl_q <= 1'b0;
            ilv_q <= dadc_pkg::ILV_RESET;
            armed_q <= 1'b0;
            qoff_q <= 1'b0;
            ld_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            tgl_q <= tgl_d;
            ilv_q <= ilv_d;
            armed_q <= armed_d;
            qoff_q <= qoff_d;
            ld_q <= ld_d;
        end
    end

    logic dual;
    logic src_q_sel;
    logic run;
    logic [7:0] i_in;
    logic [7:0] q_in;
    logic phase_q, phase_d;
    logic [7:0] i_even_q, i_even_d;
    logic [7:0] q_even_q, q_even_d;
    logic [31:0] data_q, data_d;
    logic output_data_clock_q, output_data_clock_d;
    logic output_data_clock_oe_q, output_data_clock_oe_d;
    logic i_oe_q, i_oe_d;
    logic q_oe_q, q_oe_d;
    logic strong_q, strong_d;
    logic calact_q, calact_d;

    // Output group
    always_comb begin
        dual = s_ser ? ilv_q[dadc_pkg::ILV_DUAL_EN_BIT] : (armed_q && s_flt);
        src_q_sel = dual && s_ser && ilv_q[dadc_pkg::ILV_DUAL_Q_BIT];
        i_in = src_q_sel ? q_code : i_code;
        q_in = dual ? (src_q_sel ? q_alt_code : i_alt_code) : q_code;
        run = (st_q == dadc_pkg::DS_RUN);
        phase_d = run ? ~phase_q : 1'b0;
        i_even_d = i_even_q;
        q_even_d = q_even_q;
        data_d = data_q;
        if (run && !phase_q) begin
            i_even_d = dadc_pkg::obin(i_in);
            q_even_d = dadc_pkg::obin(q_in);
        end
        if (run && phase_q) begin
            data_d = {i_even_q, dadc_pkg::obin(i_in), q_even_q, dadc_pkg::obin(q_in)};
        end
        // One clock for all buses; it moves together with data_d
        if (!run) begin
            output_data_clock_d = 1'b0;
        end else if (s_ddr) begin
            output_data_clock_d = phase_q ? ~output_data_clock_q : output_data_clock_q;
        end else begin
            output_data_clock_d = phase_q ? s_edge : ~s_edge;
        end
        // Enables follow the next state, so they fall as the busy flag rises
        output_data_clock_oe_d = (st_d == dadc_pkg::DS_RUN);
        i_oe_d = (st_d == dadc_pkg::DS_RUN);
        q_oe_d = (st_d == dadc_pkg::DS_RUN) && !qoff_d;
        strong_d = s_lvl;
        calact_d = (st_d == dadc_pkg::DS_CAL);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 1'b0;
            i_even_q <= 8'h00;
            q_even_q <= 8'h00;
            data_q <= 32'h00000000;
            output_data_clock_q <= 1'b0;
            output_data_clock_oe_q <= 1'b0;
            i_oe_q <= 1'b0;
            q_oe_q <= 1'b0;
            strong_q <= 1'b0;
            calact_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            i_even_q <= i_even_d;
            q_even_q <= q_even_d;
            data_q <= data_d;
            output_data_clock_q <= output_data_clock_d;
            output_data_clock_oe_q <= output_data_clock_oe_d;
            i_oe_q <= i_oe_d;
            q_oe_q <= q_oe_d;
            strong_q <= strong_d;
            calact_q <= calact_d;
        end
    end

    assign link.output_data_clock = output_data_clock_q;
    assign link.output_data_clock_oe = output_data_clock_oe_q;
    assign link.data_o = data_q;
    assign link.i_oe = i_oe_q;
    assign link.q_oe = q_oe_q;
    assign link.drive_strong = strong_q;
    assign link.calibration_active = calact_q;
endmodule : dadc_device
`default_nettype wire

/* common/dadc_pkg.sv */
// Shared constants, types and helpers for the dual converter output link.
// Assumes both ends run on their own pclk; nothing here holds state.
package dadc_pkg;
    localparam logic [6:0] CAL_LOW_MIN = 7'h50;
    localparam logic [6:0] CAL_START_DLY = 7'h50;
    localparam logic [7:0] CAL_MARGIN = 8'h04;
    localparam logic [3:0] REG_ILV = 4'hD;
    localparam logic [15:0] ILV_RESET = 16'h0000;
    localparam int ILV_AUTO_PHASE_BIT = 14;
    localparam int ILV_DUAL_EN_BIT = 15;
    localparam int ILV_DUAL_Q_BIT = 13;
    localparam logic [3:0] REG_HOLD = 4'h8;
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_CMD = 8'h04;
    localparam logic [7:0] APB_STAT = 8'h08;
    localparam logic [7:0] APB_DATA = 8'h0C;
    localparam int CB_PD = 0;
    localparam int CB_QPD = 1;
    localparam int CB_EDGE = 2;
    localparam int CB_LVL = 3;
    localparam int CB_DDR = 4;
    localparam int CB_SER = 5;
    localparam int CB_DLY_FLOAT = 6;
    localparam int CB_DLY_VAL = 7;
    localparam int CB_AUTO = 8;
    localparam int CB_DUAL = 9;
    localparam int CB_DUAL_Q = 10;
    localparam logic [10:0] CTRL_RESET = 11'h000;

    typedef enum logic [1:0] {
        DS_PWRUP = 2'b00,
        DS_RUN = 2'b01,
        DS_CAL = 2'b10,
        DS_PD = 2'b11
    } dadc_dev_st_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LO = 2'b01,
        H_HI = 2'b10,
        H_RUN = 2'b11
    } dadc_host_st_t;

    function automatic logic [6:0] inc7(input logic [6:0] x, input logic [6:0] lim);
        return (x == lim) ? x : x + 7'h01;
    endfunction : inc7

    // Two's complement sample to offset binary
    function automatic logic [7:0] obin(input logic [7:0] x);
        return {~x[7], x[6:0]};
    endfunction : obin
endpackage : dadc_pkg

/* common/dadc_link_if.sv */
// Pins between the converter device and the capture-side controller.
// Assumes the bench joins both ends; floating and tri-state come from the enables here.
`timescale 1ns/1ns
`default_nettype none
interface dadc_link_if;
    logic output_data_clock;
    logic output_data_clock_oe;
    logic [31:0] data_o;
    logic i_oe;
    logic q_oe;
    logic drive_strong;
    logic calibration_active;
    logic full_power_down;
    logic q_channel_power_down;
    logic output_edge_select;
    logic output_level_select;
    logic ddr_select;
    logic serial_mode;
    logic cal_request;
    logic calibration_delay_select_o;
    logic calibration_delay_select_oe;
    logic reg_toggle;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic output_data_clock_line;
    logic [31:0] data_line;
    logic calibration_delay_select_float;
    logic calibration_delay_select_level;

    // Undriven lines read low in this model
    assign output_data_clock_line = output_data_clock_oe & output_data_clock;
    assign data_line = {i_oe ? data_o[31:16] : 16'h0000, q_oe ? data_o[15:0] : 16'h0000};
    assign calibration_delay_select_float = ~calibration_delay_select_oe;
    assign calibration_delay_select_level = calibration_delay_select_oe & calibration_delay_select_o;

    modport dev(
        output output_data_clock, output_data_clock_oe, data_o, i_oe, q_oe,
        output drive_strong, calibration_active,
        input full_power_down, q_channel_power_down, output_edge_select,
        input output_level_select, ddr_select, serial_mode, cal_request,
        input calibration_delay_select_float, calibration_delay_select_level,
        input reg_toggle, reg_addr, reg_wdata
    );
    modport host(
        output full_power_down, q_channel_power_down, output_edge_select,
        output output_level_select, ddr_select, serial_mode, cal_request,
        output calibration_delay_select_o, calibration_delay_select_oe,
        output reg_toggle, reg_addr, reg_wdata,
        input output_data_clock_line, data_line, calibration_active, drive_strong
    );
endinterface : dadc_link_if
`default_nettype wire

/* hw/dadc_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes bundled bits are quasi-static or change together by design.
`timescale 1ns/1ns
`default_nettype none
module dadc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] m_q;
    logic [W-1:0] m_d;
    logic [W-1:0] q_d;

    always_comb begin
        m_d = d;
        q_d = m_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_q <= '0;
            q <= '0;
        end else begin
            m_q <= m_d;
            q <= q_d;
        end
    end
endmodule : dadc_sync
`default_nettype wire

/* hw/dadc_host.sv */
// Capture-side controller: APB registers, pin sequencing and word capture.
// Assumes an APB master on pclk and the device joined through dadc_link_if.
`timescale 1ns/1ns
`default_nettype none
module dadc_host #(
    parameter int FLUSH_WORDS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_fault,
    output logic cap_valid,
    output logic [31:0] cap_data,
    dadc_link_if.host link
);
    if (FLUSH_WORDS < 0 || FLUSH_WORDS > 255) begin : g_bad_param
        $error("dadc_host: FLUSH_WORDS out of range");
    end

    logic [33:0] syn;
    logic s_clk;
    logic s_act;
    logic [31:0] s_data;

    dadc_sync #(.W(34)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({link.output_data_clock_line, link.calibration_active, link.data_line}),
        .q(syn)
    );
    assign {s_clk, s_act, s_data} = syn;

    dadc_pkg::dadc_host_st_t st_q, st_d;
    logic [10:0] ctrl_q, ctrl_d;
    logic pend_q, pend_d;
    logic [7:0] cnt_q, cnt_d;
    logic [15:0] sent_q, sent_d;
    logic [15:0] want;
    logic [3:0] wcnt_q, wcnt_d;
    logic rtgl_q, rtgl_d;
    logic pdpin_q, pdpin_d;
    logic calpin_q, calpin_d;
    logic prev_q, prev_d;
    logic ddr_q, ddr_d;
    logic [7:0] flush_q, flush_d;
    logic capv_q, capv_d;
    logic [31:0] capd_q, capd_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic cal_busy, synced, setup, wr, take, rise, fall;

    always_comb begin
        st_d = st_q;
        ctrl_d = ctrl_q;
        pend_d = pend_q;
        cnt_d = cnt_q;
        sent_d = sent_q;
        wcnt_d = wcnt_q;
        rtgl_d = rtgl_q;
        pdpin_d = pdpin_q;
        calpin_d = calpin_q;
        setup = psel && !penable;
        wr = psel && penable && pready && pwrite;
        cal_busy = pend_q || (st_q != dadc_pkg::H_IDLE);
        want = 16'h0000;
        want[dadc_pkg::ILV_DUAL_EN_BIT] = ctrl_q[dadc_pkg::CB_DUAL] && !cal_busy;
        want[dadc_pkg::ILV_AUTO_PHASE_BIT] = ctrl_q[dadc_pkg::CB_AUTO] && !cal_busy
                                             && !pdpin_q;
        want[dadc_pkg::ILV_DUAL_Q_BIT] = ctrl_q[dadc_pkg::CB_DUAL_Q];
        synced = (wcnt_q == 4'h0) && (sent_q == want);
        if (wcnt_q != 4'h0) begin
            wcnt_d = wcnt_q - 4'h1;
        end else if (sent_q != want) begin
            sent_d = want;
            rtgl_d = ~rtgl_q;
            wcnt_d = dadc_pkg::REG_HOLD;
        end
        // Release only after auto phase is known off in the device
        if (ctrl_q[dadc_pkg::CB_PD]) begin
            pdpin_d = 1'b1;
        end else if (synced) begin
            pdpin_d = 1'b0;
        end
        case (st_q)
            dadc_pkg::H_IDLE: begin
                if (pdpin_q) begin
                    pend_d = 1'b0;
                end else if (pend_q && synced) begin
                    pend_d = 1'b0;
                    st_d = dadc_pkg::H_LO;
                    cnt_d = 8'h00;
                    calpin_d = 1'b0;
                end
            end
            dadc_pkg::H_LO: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == {1'b0, dadc_pkg::CAL_LOW_MIN} + dadc_pkg::CAL_MARGIN) begin
                    st_d = dadc_pkg::H_HI;
                    cnt_d = 8'h00;
                    calpin_d = 1'b1;
                end
            end
            // Waits for the busy flag; no device answer means a stuck wait
            dadc_pkg::H_HI: begin
                if (cnt_q != 8'hFF) begin
                    cnt_d = cnt_q + 8'h01;
                end
                if (s_act && cnt_q > {1'b0, dadc_pkg::CAL_START_DLY}) begin
                    st_d = dadc_pkg::H_RUN;
                    calpin_d = 1'b0;
                end
            end
            dadc_pkg::H_RUN: begin
                if (!s_act) begin
                    st_d = dadc_pkg::H_IDLE;
                end
            end
            default: begin
                st_d = dadc_pkg::H_IDLE;
            end
        endcase
        if (wr && paddr == dadc_pkg::APB_CTRL) begin
            ctrl_d = pwdata[10:0];
        end
        if (wr && paddr == dadc_pkg::APB_CMD && pwdata[0]) begin
            pend_d = 1'b1;
        end
        if (clock_fault || (wr && paddr == dadc_pkg::APB_CMD && pwdata[1])) begin
            ctrl_d[dadc_pkg::CB_AUTO] = 1'b0;
        end
        pready_d = setup;
        pslverr_d = setup && paddr != dadc_pkg::APB_CTRL && paddr != dadc_pkg::APB_CMD
                    && paddr != dadc_pkg::APB_STAT && paddr != dadc_pkg::APB_DATA;
        case (paddr)
            dadc_pkg::APB_CTRL: prdata_d = {21'h000000, ctrl_q};
            dadc_pkg::APB_STAT: prdata_d = {28'h0000000, pdpin_q, s_act, flush_q != 8'h00,
                                            cal_busy};
            dadc_pkg::APB_DATA: prdata_d = capd_q;
            default: prdata_d = 32'h00000000;
        endcase
        if (!setup) begin
            prdata_d = prdata;
        end
    end

    // Capture group: data and clock share one synchroniser delay
    always_comb begin
        rise = s_clk && !prev_q;
        fall = !s_clk && prev_q;
        prev_d = s_clk;
        ddr_d = rise || fall;
        take = ctrl_q[dadc_pkg::CB_DDR] ? ddr_q : (ctrl_q[dadc_pkg::CB_EDGE] ? fall : rise);
        capv_d = 1'b0;
        capd_d = capd_q;
        flush_d = flush_q;
        if (take && flush_q == 8'h00) begin
            capv_d = 1'b1;
            capd_d = s_data;
        end
        if (pdpin_q || ctrl_q[dadc_pkg::CB_QPD] || s_act) begin
            flush_d = 8'(FLUSH_WORDS);
        end else if (take && flush_q != 8'h00) begin
            flush_d = flush_q - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= dadc_pkg::H_IDLE;
            ctrl_q <= dadc_pkg::CTRL_RESET;
            pend_q <= 1'b0;
            cnt_q <= 8'h00;
            sent_q <= dadc_pkg::ILV_RESET;
            wcnt_q <= 4'h0;
            rtgl_q <= 1'b0;
            pdpin_q <= 1'b0;
            calpin_q <= 1'b0;
            prev_q <= 1'b0;
            ddr_q <= 1'b0;
            flush_q <= 8'(FLUSH_WORDS);
            capv_q <= 1'b0;
            capd_q <= 32'h00000000;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            pend_q <= pend_d;
            cnt_q <= cnt_d;
            sent_q <= sent_d;
            wcnt_q <= wcnt_d;
            rtgl_q <= rtgl_d;
            pdpin_q <= pdpin_d;
            calpin_q <= calpin_d;
            prev_q <= prev_d;
            ddr_q <= ddr_d;
            flush_q <= flush_d;
            capv_q <= capv_d;
            capd_q <= capd_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    assign cap_valid = capv_q;
    assign cap_data = capd_q;
    assign link.full_power_down = pdpin_q;
    assign link.q_channel_power_down = ctrl_q[dadc_pkg::CB_QPD];
    assign link.output_edge_select = ctrl_q[dadc_pkg::CB_EDGE];
    assign link.output_level_select = ctrl_q[dadc_pkg::CB_LVL];
    assign link.ddr_select = ctrl_q[dadc_pkg::CB_DDR];
    assign link.serial_mode = ctrl_q[dadc_pkg::CB_SER];
    assign link.cal_request = calpin_q;
    // Reset value drives the delay pin low before any float
    assign link.calibration_delay_select_o = ctrl_q[dadc_pkg::CB_DLY_VAL];
    assign link.calibration_delay_select_oe = ~ctrl_q[dadc_pkg::CB_DLY_FLOAT];
    assign link.reg_toggle = rtgl_q;
    assign link.reg_addr = dadc_pkg::REG_ILV;
    assign link.reg_wdata = sent_q;
endmodule : dadc_host
`default_nettype wire

/* hw/dadc_host_fix.sv */
// Holds no logic; the capture-side controller lives in dadc_host.sv.

/* verif/dadc_props.sv */
// Link checker: output clock, data enables and calibration timing.
// Assumes pins taken straight from the interface joining both ends.
`timescale 1ns/1ns
`default_nettype none
module dadc_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic output_data_clock,
    input wire logic output_data_clock_oe,
    input wire logic [31:0] data_o,
    input wire logic i_oe,
    input wire logic q_oe,
    input wire logic calibration_active,
    input wire logic full_power_down,
    input wire logic q_channel_power_down,
    input wire logic output_edge_select,
    input wire logic ddr_select
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Eight cycles outlast the two-flop pin sync
    sequence s_held(x);
        x [*8];
    endsequence
    sequence s_sdr;
        s_held(!ddr_select && output_data_clock_oe && $stable(output_edge_select));
    endsequence
    a_cal_tristate: assert property (calibration_active |-> !(output_data_clock_oe || i_oe || q_oe))
        else $error("outputs driven in calibration");
    a_full_pd_off: assert property (s_held(full_power_down) |-> !(i_oe || q_oe))
        else $error("data driven in power-down");
    a_q_pd_off: assert property (s_held(q_channel_power_down) |-> !q_oe)
        else $error("q data driven in q power-down");
    a_no_cal_pd: assert property (s_held(full_power_down) |-> !$rose(calibration_active))
        else $error("calibration started in power-down");
    a_cal_whole: assert property ($rose(calibration_active) |-> calibration_active [*8])
        else $error("calibration cut short");
    a_sdr_rate: assert property (s_sdr |-> $changed(output_data_clock))
        else $error("sdr clock missed a toggle");
    a_edge_sel: assert property (s_sdr ##0 $changed(data_o) |-> output_data_clock == output_edge_select)
        else $error("data changed on wrong clock edge");
    a_ddr_rate: assert property (s_held(ddr_select && output_data_clock_oe) ##0
        $changed(output_data_clock) |=> $stable(output_data_clock) || !output_data_clock_oe)
        else $error("ddr clock too fast");
endmodule : dadc_props
`default_nettype wire

/* verif/tb_dual_adc_output_demux_control.sv */
// Bench: both ends joined by the link, host driven over APB.
// Assumes package, interface and both design ends compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_dual_adc_output_demux_control;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
    logic pready, pslverr, cap_valid;
    logic [7:0] paddr = 8'h00, ic = 8'h80, qc = 8'h7F;
    logic [31:0] pwdata = 32'h0, prdata, cap_data, r;
    logic cf = 1'h0;
    logic [31:0] ctl [6] = '{32'h008, 32'h004, 32'h014, 32'h00A, 32'h040, 32'h620};
    logic [31:0] xp [6] = '{32'h0000FFFF, 32'h4141FFFF, 32'h8282FFFF, 32'hC3C30000,
        32'h04040505, 32'hFFFFFEFE};
    int num_errors = 0, checks = 0, cyc = 0;
    dadc_link_if lnk();
    dadc_device #(.PWRUP_SHORT(8), .PWRUP_LONG(16), .CAL_CYCLES(16)) i_dadc_device(.pclk(pclk),
        .presetn(presetn), .i_code(ic), .i_alt_code(ic ^ 8'h01), .q_code(qc),
        .q_alt_code(qc ^ 8'h01), .link(lnk));
    dadc_host i_dadc_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_fault(cf), .cap_valid(cap_valid), .cap_data(cap_data),
        .link(lnk));
    dadc_props i_dadc_props(.pclk(pclk), .presetn(presetn), .data_o(lnk.data_o),
        .output_data_clock(lnk.output_data_clock), .i_oe(lnk.i_oe), .q_oe(lnk.q_oe),
        .output_data_clock_oe(lnk.output_data_clock_oe), .ddr_select(lnk.ddr_select),
        .calibration_active(lnk.calibration_active), .full_power_down(lnk.full_power_down),
        .q_channel_power_down(lnk.q_channel_power_down),
        .output_edge_select(lnk.output_edge_select));
    always #5 pclk = ~pclk;
    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // Settle past the flush, then take the next captured word
    task automatic cap(input logic [31:0] exp);
        int n;
        n = 0;
        repeat (80) @(negedge pclk);
        while (cap_valid !== 1'h1 && n < 100) begin
            @(negedge pclk);
            n++;
        end
        chk(cap_valid, 32'h1);
        chk(cap_data, exp);
    endtask : cap
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        repeat (60) @(posedge pclk);
        apb(1'h0, 8'h10, 32'h0);
        chk({r[30:0], e}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            apb(1'h1, dadc_pkg::APB_CTRL, ctl[k]);
            ic <= 8'h80 + 8'(k) * 8'h41;
            apb(1'h0, dadc_pkg::APB_CTRL, 32'h0);
            chk(r, ctl[k]);
            if (k == 3) begin
                // Capture is held off during Q power-down; the I lanes still run
                repeat (80) @(negedge pclk);
                chk(lnk.data_line, xp[k]);
            end else begin
                cap(xp[k]);
            end
            chk(lnk.drive_strong, ctl[k][3]);
        end
        apb(1'h1, dadc_pkg::APB_CTRL, 32'h100);
        cf <= 1'h1;
        @(posedge pclk);
        cf <= 1'h0;
        apb(1'h0, dadc_pkg::APB_CTRL, 32'h0);
        chk(r, 32'h0);
        apb(1'h1, dadc_pkg::APB_CTRL, 32'h001);
        repeat (40) @(negedge pclk);
        chk(lnk.data_line, 32'h0);
        apb(1'h1, dadc_pkg::APB_CMD, 32'h001);
        repeat (300) @(posedge pclk);
        apb(1'h0, dadc_pkg::APB_STAT, 32'h0);
        chk(r & 32'hF, 32'hA);
        apb(1'h1, dadc_pkg::APB_CTRL, 32'h0);
        cap(32'h4545FFFF);
        apb(1'h1, dadc_pkg::APB_CMD, 32'h001);
        do apb(1'h0, dadc_pkg::APB_STAT, 32'h0); while (r[0] !== 1'h0);
        cap(32'h4545FFFF);
        tally_and_finish();
    end
endmodule : tb_dual_adc_output_demux_control
`default_nettype wire
